// *** spd_pkg.sv ***
// Shared constants and types for the serial data port and its far end.
// Assumes one 200 MHz system clock drives both ends.
// What this block does
// - Data register write loads transmit buffer
// - Master write starts a serial transfer
// - Data read returns receive buffer, resets zero
// - Idle level one inverts the clock
// - Select low two clocks before edge
// - Last edge two clocks before deselect
// - Slave output valid four clocks after select
// - Slave output released four clocks after deselect
// - Master data set up two clocks
// - Master data held two clocks
// - Slave output updates four clocks after shift
// - Clock is system over 2(divider+1)
// - Phase picks first or second sampling edge
// - Busy write sets sticky collision, raises interrupt
// - Single-master mode drives select from mode
package spd_pkg;
	localparam logic [7:0] DATA_OFFSET = 8'ha3;
	localparam logic [7:0] DATA_RESET = 8'h00;
	localparam int BYTE_BITS = 8;
	localparam int FIFO_DEPTH = 16;
	localparam logic [3:0] BIT_LAST = 4'h7;
	localparam logic [3:0] BIT_DONE = 4'h8;
	localparam logic [3:0] BIT_FIRST = 4'h0;
	localparam logic [3:0] EDGE_LAST = 4'hf;
	localparam int PIN_MISO = 0;
	localparam int PIN_MOSI = 1;
	localparam int PIN_SCK = 2;
	localparam int PIN_NSS = 3;
	localparam int PIN_COUNT = 4;
	localparam logic [3:0] PINS_RESET = 4'h8;
	localparam logic [1:0] MODE_THREE_WIRE = 2'h0;
	localparam int MODE_DRIVE_BIT = 1;
	localparam int MODE_LEVEL_BIT = 0;
	localparam int SYS_PERIOD_PS = 5000;
	localparam int T_SEL_LEAD_PS = 10000;
	localparam int T_SEL_LAG_PS = 10000;
	localparam int T_SLV_SCK_PS = 25000;
	localparam int T_SLV_OUT_PS = 20000;
	localparam int SYNC_STAGES = 2;
	localparam int SEL_LEAD_CYC = (T_SEL_LEAD_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int SEL_LAG_CYC = (T_SEL_LAG_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int SLV_SCK_CYC = (T_SLV_SCK_PS + SYS_PERIOD_PS - 1) / SYS_PERIOD_PS;
	localparam int SLV_OUT_CYC = T_SLV_OUT_PS / SYS_PERIOD_PS;
	localparam int FAR_HALF_INT = (SLV_SCK_CYC > SLV_OUT_CYC + SYNC_STAGES + 1) ?
		SLV_SCK_CYC : SLV_OUT_CYC + SYNC_STAGES + 1;
	localparam logic [7:0] FAR_HALF_MIN = 8'(FAR_HALF_INT);
	localparam logic [7:0] LEAD_M1 = 8'(SEL_LEAD_CYC - 1);
	localparam logic [7:0] LAG_M1 = 8'(SEL_LAG_CYC - 1);
	localparam logic [7:0] COUNT_ONE = 8'h01;
	typedef enum logic [1:0] {SPD_IDLE, SPD_LEAD, SPD_RUN, SPD_TAIL} spd_state_e;
endpackage

// *** spd_link_if.sv ***
// Serial link between the port and its far end, with wire resolution.
// Enables are active low; an undriven select floats high, others low.
`timescale 1ns/1ps
`default_nettype none
interface spd_link_if;
	logic dev_sck_out, dev_sck_oe_n, dev_mosi_out, dev_mosi_oe_n;
	logic dev_miso_out, dev_miso_oe_n, dev_nss_out, dev_nss_oe_n;
	logic far_sck_out, far_sck_oe_n, far_mosi_out, far_mosi_oe_n;
	logic far_miso_out, far_miso_oe_n, far_nss_out, far_nss_oe_n;
	logic sck_line, mosi_line, miso_line, nss_line;
	assign sck_line = !dev_sck_oe_n ? dev_sck_out : (!far_sck_oe_n ? far_sck_out : 1'b0);
	assign mosi_line = !dev_mosi_oe_n ? dev_mosi_out : (!far_mosi_oe_n ? far_mosi_out : 1'b0);
	assign miso_line = !dev_miso_oe_n ? dev_miso_out : (!far_miso_oe_n ? far_miso_out : 1'b0);
	assign nss_line = !dev_nss_oe_n ? dev_nss_out : (!far_nss_oe_n ? far_nss_out : 1'b1);
	modport dev (
		output dev_sck_out, dev_sck_oe_n, dev_mosi_out, dev_mosi_oe_n,
		output dev_miso_out, dev_miso_oe_n, dev_nss_out, dev_nss_oe_n,
		input sck_line, mosi_line, miso_line, nss_line
	);
	modport far (
		output far_sck_out, far_sck_oe_n, far_mosi_out, far_mosi_oe_n,
		output far_miso_out, far_miso_oe_n, far_nss_out, far_nss_oe_n,
		input sck_line, mosi_line, miso_line, nss_line
	);
endinterface
`default_nettype wire

// *** spd_fifo.sv ***
// Flip-flop FIFO with valid/ready on both sides.
// Same clock on both sides; full and empty come from an entry count.
`timescale 1ns/1ps
`default_nettype none
module spd_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 16
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Filling side
	input wire logic in_valid_in,
	output logic in_ready_out,
	input wire logic [WIDTH-1:0] in_data_in,
	// Draining side
	output logic out_valid_out,
	input wire logic out_ready_in,
	output logic [WIDTH-1:0] out_data_out
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem_reg [DEPTH];
	logic [AW-1:0] wr_ptr_reg, rd_ptr_reg;
	logic [AW:0] count_reg;
	wire push_w = in_valid_in & in_ready_out & ce_in;
	wire pop_w = out_valid_out & out_ready_in & ce_in;
	assign in_ready_out = count_reg != (AW+1)'(DEPTH);
	assign out_valid_out = count_reg != '0;
	assign out_data_out = mem_reg[rd_ptr_reg];
	always_ff @(posedge clk_in)
	begin
		if (push_w)
			mem_reg[wr_ptr_reg] <= in_data_in;
	end
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
			count_reg <= '0;
		end
		else
		begin
			if (push_w)
				wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH - 1)) ? '0 : wr_ptr_reg + 1'b1;
			if (pop_w)
				rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH - 1)) ? '0 : rd_ptr_reg + 1'b1;
			if (push_w != pop_w)
				count_reg <= push_w ? count_reg + 1'b1 : count_reg - 1'b1;
		end
	end
endmodule
`default_nettype wire

// *** spd_device.sv ***
// Serial data port: data register, master clock generator, slave engine.
// Config bits arrive as plain inputs; the data register sits on a byte
// register port at its own offset. Link pins are asynchronous.
`timescale 1ns/1ps
`default_nettype none
module spd_device
	import spd_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Register port
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic sfr_rd_in,
	input wire logic [7:0] sfr_wdata_in,
	output logic [7:0] sfr_rdata_out,
	// Configuration
	input wire logic port_enable_in,
	input wire logic master_en_in,
	input wire logic clock_idle_level_in,
	input wire logic clock_sample_phase_in,
	input wire logic [7:0] clock_rate_divider_in,
	input wire logic [1:0] select_pin_mode_in,
	// Flag clears
	input wire logic clr_done_in,
	input wire logic clr_collision_in,
	input wire logic clr_overrun_in,
	// Status
	output logic busy_out,
	output logic done_flag_out,
	output logic write_collision_flag_out,
	output logic overrun_flag_out,
	output logic tx_empty_out,
	output logic rx_empty_out,
	output logic irq_out,
	// Link
	spd_link_if.dev link
);
	logic [PIN_COUNT-1:0] sync1_reg, sync2_reg;
	logic sck_s3_reg, sel_prev_reg;
	spd_state_e state_reg;
	logic [7:0] div_reg;
	logic [3:0] edge_cnt_reg, bit_cnt_reg;
	logic sck_lvl_reg, in_latch_reg;
	logic [7:0] sr_reg, tx_reg, rx_word_reg, rdata_reg;
	logic tx_empty_reg, push_reg;
	logic done_reg, write_collision_flag_reg, ovr_reg;
	logic fifo_ready, fifo_valid;
	logic [7:0] fifo_data;

	// Decoding
	wire [PIN_COUNT-1:0] pins_raw_w = {link.nss_line, link.sck_line, link.mosi_line,
		link.miso_line};
	wire master_w = port_enable_in & master_en_in;
	wire slave_w = port_enable_in & ~master_en_in;
	wire three_wire_w = select_pin_mode_in == MODE_THREE_WIRE;
	wire sel_w = three_wire_w | ~sync2_reg[PIN_NSS];
	wire sel_rise_w = slave_w & sel_w & ~sel_prev_reg;
	wire run_w = state_reg == SPD_RUN;
	wire tick_w = run_w & (div_reg == clock_rate_divider_in);
	wire m_lead_w = tick_w & ~sck_lvl_reg;
	wire m_trail_w = tick_w & sck_lvl_reg;
	wire s_now_w = sync2_reg[PIN_SCK] ^ clock_idle_level_in;
	wire s_prev_w = sck_s3_reg ^ clock_idle_level_in;
	wire s_lead_w = slave_w & sel_w & s_now_w & ~s_prev_w;
	wire s_trail_w = slave_w & sel_w & ~s_now_w & s_prev_w;
	wire lead_w = master_w ? m_lead_w : s_lead_w;
	wire trail_w = master_w ? m_trail_w : s_trail_w;
	wire sample_w = clock_sample_phase_in ? trail_w : lead_w;
	wire shift_w = clock_sample_phase_in ? lead_w : trail_w;
	wire in_bit_w = master_w ? sync2_reg[PIN_MISO] : sync2_reg[PIN_MOSI];
	wire done_w = sample_w & (bit_cnt_reg == BIT_LAST);
	wire busy_w = run_w | (slave_w & sel_w & (bit_cnt_reg != BIT_DONE));
	wire data_hit_w = sfr_addr_in == DATA_OFFSET;
	wire wr_hit_w = ce_in & sfr_wr_in & data_hit_w;
	wire rd_hit_w = ce_in & sfr_rd_in & data_hit_w;
	wire collision_w = wr_hit_w & busy_w;
	wire accept_w = wr_hit_w & ~busy_w;
	// Master waits for room in the receive FIFO, so it never overruns
	wire start_w = master_w & (state_reg == SPD_IDLE) & ~tx_empty_reg & fifo_ready;
	wire reload_w = slave_w & three_wire_w & done_w;
	wire load_w = start_w | sel_rise_w | reload_w;

	// Pin synchronisers; stage one feeds only stage two
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sync1_reg <= PINS_RESET;
			sync2_reg <= PINS_RESET;
			sck_s3_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			sync1_reg <= pins_raw_w;
			sync2_reg <= sync1_reg;
			sck_s3_reg <= sync2_reg[PIN_SCK];
			sel_prev_reg <= slave_w & sel_w;
		end
	end

	// Master clock generator, half period of divider+1 clocks
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_reg <= SPD_IDLE;
			div_reg <= '0;
			edge_cnt_reg <= '0;
			sck_lvl_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			case (state_reg)
				SPD_IDLE:
				begin
					div_reg <= '0;
					edge_cnt_reg <= '0;
					sck_lvl_reg <= 1'b0;
					if (start_w)
						state_reg <= SPD_RUN;
				end
				SPD_RUN:
				begin
					if (!master_w)
						state_reg <= SPD_IDLE;
					else if (tick_w)
					begin
						div_reg <= '0;
						sck_lvl_reg <= ~sck_lvl_reg;
						edge_cnt_reg <= edge_cnt_reg + 1'b1;
						if (edge_cnt_reg == EDGE_LAST)
							state_reg <= SPD_IDLE;
					end
					else
						div_reg <= div_reg + 1'b1;
				end
				default:
					state_reg <= SPD_IDLE;
			endcase
		end
	end

	// Shift register shared by master and slave
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sr_reg <= DATA_RESET;
			bit_cnt_reg <= BIT_DONE;
			in_latch_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			if (load_w)
			begin
				sr_reg <= tx_reg;
				bit_cnt_reg <= BIT_FIRST;
			end
			else
			begin
				if (sample_w && bit_cnt_reg != BIT_DONE)
				begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
					in_latch_reg <= in_bit_w;
				end
				if (shift_w && bit_cnt_reg != BIT_FIRST && bit_cnt_reg != BIT_DONE)
					sr_reg <= {sr_reg[BYTE_BITS-2:0], in_latch_reg};
			end
		end
	end

	// Transmit buffer and receive push
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			tx_reg <= DATA_RESET;
			tx_empty_reg <= 1'b1;
			rx_word_reg <= DATA_RESET;
			push_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			if (accept_w)
			begin
				tx_reg <= sfr_wdata_in;
				tx_empty_reg <= 1'b0;
			end
			else if (load_w)
				tx_empty_reg <= 1'b1;
			push_reg <= done_w;
			if (done_w)
				rx_word_reg <= {sr_reg[BYTE_BITS-2:0], in_bit_w};
		end
	end

	// Sticky flags: a set in the clearing cycle wins
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			done_reg <= 1'b0;
			write_collision_flag_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			done_reg <= push_reg | (done_reg & ~clr_done_in);
			write_collision_flag_reg <= collision_w | (write_collision_flag_reg & ~clr_collision_in);
			ovr_reg <= (push_reg & ~fifo_ready) | (ovr_reg & ~clr_overrun_in);
		end
	end

	// Read data is registered; an empty FIFO repeats the last byte
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
			rdata_reg <= DATA_RESET;
		else if (rd_hit_w && fifo_valid)
			rdata_reg <= fifo_data;
	end

	spd_fifo #(
		.WIDTH(BYTE_BITS),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.clk_in(clk_in),
		.arst_n_in(arst_n_in),
		.ce_in(ce_in),
		.in_valid_in(push_reg),
		.in_ready_out(fifo_ready),
		.in_data_in(rx_word_reg),
		.out_valid_out(fifo_valid),
		.out_ready_in(rd_hit_w),
		.out_data_out(fifo_data)
	);

	assign sfr_rdata_out = rdata_reg;
	assign busy_out = busy_w;
	assign done_flag_out = done_reg;
	assign write_collision_flag_out = write_collision_flag_reg;
	assign overrun_flag_out = ovr_reg;
	assign tx_empty_out = tx_empty_reg;
	assign rx_empty_out = ~fifo_valid;
	assign irq_out = done_reg | write_collision_flag_reg | ovr_reg;

	// Pin drivers; enables are low while driving
	assign link.dev_sck_out = sck_lvl_reg ^ clock_idle_level_in;
	assign link.dev_sck_oe_n = ~master_w;
	assign link.dev_mosi_out = sr_reg[BYTE_BITS-1];
	assign link.dev_mosi_oe_n = ~master_w;
	assign link.dev_miso_out = sr_reg[BYTE_BITS-1];
	assign link.dev_miso_oe_n = ~(slave_w & sel_w);
	assign link.dev_nss_out = select_pin_mode_in[MODE_LEVEL_BIT];
	assign link.dev_nss_oe_n = ~(port_enable_in & select_pin_mode_in[MODE_DRIVE_BIT]);
endmodule
`default_nettype wire

// *** spd_far_end.sv ***
// Far end of the link: a master or slave that keeps the slave-side limits.
// Same system clock as the port; its pin inputs are still synchronised.
`timescale 1ns/1ps
`default_nettype none
module spd_far_end
	import spd_pkg::*;
(
	// Clock, reset, enable
	input wire logic clk_in,
	input wire logic arst_n_in,
	input wire logic ce_in,
	// Configuration
	input wire logic act_master_in,
	input wire logic clock_idle_level_in,
	input wire logic clock_sample_phase_in,
	input wire logic [7:0] half_period_in,
	// User side
	input wire logic start_in,
	input wire logic [7:0] tx_byte_in,
	output logic [7:0] rx_byte_out,
	output logic rx_valid_out,
	output logic busy_out,
	// Link
	spd_link_if.far link
);
	logic [PIN_COUNT-1:0] sync1_reg, sync2_reg;
	logic sck_s3_reg, sel_prev_reg;
	spd_state_e state_reg;
	logic [7:0] cnt_reg, sr_reg, rx_reg;
	logic [3:0] edge_cnt_reg, bit_cnt_reg;
	logic lvl_reg, in_latch_reg, valid_reg;

	wire [PIN_COUNT-1:0] pins_raw_w = {link.nss_line, link.sck_line, link.mosi_line,
		link.miso_line};
	// Half period floor covers slave clock width and output delay plus sync
	wire [7:0] half_w = (half_period_in < FAR_HALF_MIN) ? FAR_HALF_MIN : half_period_in;
	wire tick_w = (state_reg == SPD_RUN) & (cnt_reg == half_w - COUNT_ONE);
	wire sel_w = ~act_master_in & ~sync2_reg[PIN_NSS];
	wire sel_rise_w = sel_w & ~sel_prev_reg;
	wire s_now_w = sync2_reg[PIN_SCK] ^ clock_idle_level_in;
	wire s_prev_w = sck_s3_reg ^ clock_idle_level_in;
	wire lead_w = act_master_in ? tick_w & ~lvl_reg : sel_w & s_now_w & ~s_prev_w;
	wire trail_w = act_master_in ? tick_w & lvl_reg : sel_w & ~s_now_w & s_prev_w;
	wire sample_w = clock_sample_phase_in ? trail_w : lead_w;
	wire shift_w = clock_sample_phase_in ? lead_w : trail_w;
	wire in_bit_w = act_master_in ? sync2_reg[PIN_MISO] : sync2_reg[PIN_MOSI];
	wire start_w = act_master_in & start_in & (state_reg == SPD_IDLE);
	wire load_w = start_w | sel_rise_w;

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sync1_reg <= PINS_RESET;
			sync2_reg <= PINS_RESET;
			sck_s3_reg <= 1'b0;
			sel_prev_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			sync1_reg <= pins_raw_w;
			sync2_reg <= sync1_reg;
			sck_s3_reg <= sync2_reg[PIN_SCK];
			sel_prev_reg <= sel_w;
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			state_reg <= SPD_IDLE;
			cnt_reg <= '0;
			edge_cnt_reg <= '0;
			lvl_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			cnt_reg <= cnt_reg + COUNT_ONE;
			case (state_reg)
				SPD_IDLE:
				begin
					cnt_reg <= '0;
					edge_cnt_reg <= '0;
					lvl_reg <= 1'b0;
					if (start_w)
						state_reg <= SPD_LEAD;
				end
				SPD_LEAD:
					if (cnt_reg == LEAD_M1)
					begin
						cnt_reg <= '0;
						state_reg <= SPD_RUN;
					end
				SPD_RUN:
					if (tick_w)
					begin
						cnt_reg <= '0;
						lvl_reg <= ~lvl_reg;
						edge_cnt_reg <= edge_cnt_reg + 1'b1;
						if (edge_cnt_reg == EDGE_LAST)
							state_reg <= SPD_TAIL;
					end
				SPD_TAIL:
					if (cnt_reg == LAG_M1)
						state_reg <= SPD_IDLE;
				default:
					state_reg <= SPD_IDLE;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sr_reg <= DATA_RESET;
			bit_cnt_reg <= BIT_DONE;
			in_latch_reg <= 1'b0;
			rx_reg <= DATA_RESET;
			valid_reg <= 1'b0;
		end
		else if (ce_in)
		begin
			valid_reg <= sample_w & (bit_cnt_reg == BIT_LAST);
			if (sample_w && bit_cnt_reg == BIT_LAST)
				rx_reg <= {sr_reg[BYTE_BITS-2:0], in_bit_w};
			if (load_w)
			begin
				sr_reg <= tx_byte_in;
				bit_cnt_reg <= BIT_FIRST;
			end
			else
			begin
				if (sample_w && bit_cnt_reg != BIT_DONE)
				begin
					bit_cnt_reg <= bit_cnt_reg + 1'b1;
					in_latch_reg <= in_bit_w;
				end
				if (shift_w && bit_cnt_reg != BIT_FIRST && bit_cnt_reg != BIT_DONE)
					sr_reg <= {sr_reg[BYTE_BITS-2:0], in_latch_reg};
			end
		end
	end

	assign rx_byte_out = rx_reg;
	assign rx_valid_out = valid_reg;
	assign busy_out = (state_reg != SPD_IDLE) | (sel_w & bit_cnt_reg != BIT_DONE);
	assign link.far_sck_out = lvl_reg ^ clock_idle_level_in;
	assign link.far_sck_oe_n = ~act_master_in;
	assign link.far_mosi_out = sr_reg[BYTE_BITS-1];
	assign link.far_mosi_oe_n = ~act_master_in;
	assign link.far_miso_out = sr_reg[BYTE_BITS-1];
	assign link.far_miso_oe_n = ~sel_w;
	assign link.far_nss_out = state_reg == SPD_IDLE;
	assign link.far_nss_oe_n = ~act_master_in;
endmodule
`default_nettype wire

// *** spd_link_checker.sv ***
// Checker for the port and far end on one link: pin timing, rate, flags.
// Assumes one clock for both ends; inputs are link and port signals.
`timescale 1ns/1ps
`default_nettype none
module spd_link_checker
	import spd_pkg::*;
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic arst_n_in,
	// Link
	input wire logic sck_line,
	input wire logic nss_line,
	input wire logic dev_sck_oe_n,
	input wire logic dev_miso_out,
	input wire logic dev_miso_oe_n,
	input wire logic far_nss_oe_n,
	// Port side
	input wire logic master_en_in,
	input wire logic clock_idle_level_in,
	input wire logic [7:0] clock_rate_divider_in,
	input wire logic [1:0] select_pin_mode_in,
	input wire logic [7:0] sfr_addr_in,
	input wire logic sfr_wr_in,
	input wire logic clr_collision_in,
	input wire logic busy_out,
	input wire logic write_collision_flag_out,
	input wire logic irq_out
);
	logic sck_prev_reg, nss_prev_reg, sck_moved, moved, data_wr;
	logic [8:0] hold_cnt_reg, half_len;
	logic [3:0] quiet_cnt_reg;
	assign sck_moved = sck_line != sck_prev_reg;
	assign moved = sck_moved || nss_line != nss_prev_reg;
	assign half_len = 9'(clock_rate_divider_in) + 9'h001;
	assign data_wr = sfr_wr_in && sfr_addr_in == DATA_OFFSET;
	// Run length of the clock level, and quiet time of clock and select
	always_ff @(posedge clk_in or negedge arst_n_in)
	begin
		if (!arst_n_in)
		begin
			sck_prev_reg <= 1'b0;
			nss_prev_reg <= 1'b1;
			hold_cnt_reg <= 9'h1ff;
			quiet_cnt_reg <= 4'hf;
		end
		else
		begin
			sck_prev_reg <= sck_line;
			nss_prev_reg <= nss_line;
			hold_cnt_reg <= sck_moved ? 9'h001 : hold_cnt_reg + 9'(hold_cnt_reg != 9'h1ff);
			quiet_cnt_reg <= moved ? 4'h1 : quiet_cnt_reg + 4'(quiet_cnt_reg != 4'hf);
		end
	end
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!arst_n_in);
	// Config changes need three quiet cycles before the clock is judged
	AST_CLK_HALF: assert property (!dev_sck_oe_n && !$past(dev_sck_oe_n, 3) &&
		$past(clock_idle_level_in, 3) == clock_idle_level_in && sck_moved &&
		sck_line == clock_idle_level_in |-> hold_cnt_reg == half_len)
		else $error("active clock half differs from divider plus one");
	AST_CLK_IDLE: assert property (!dev_sck_oe_n && !$past(dev_sck_oe_n, 3) &&
		$past(clock_idle_level_in, 3) == clock_idle_level_in && !sck_moved &&
		hold_cnt_reg > half_len |-> sck_line == clock_idle_level_in)
		else $error("long clock level is not the idle level");
	AST_WR_START: assert property (data_wr && master_en_in && !busy_out |-> ##[1:3] busy_out)
		else $error("master write did not start a transfer");
	AST_COLL_SET: assert property (data_wr && busy_out |=> write_collision_flag_out && irq_out)
		else $error("busy write did not flag a collision");
	AST_COLL_KEEP: assert property (write_collision_flag_out && !clr_collision_in |=>
		write_collision_flag_out)
		else $error("collision flag cleared without a clear");
	AST_SEL_DRIVE: assert property (select_pin_mode_in[MODE_DRIVE_BIT] &&
		$past(select_pin_mode_in, 2) == select_pin_mode_in |->
		nss_line == select_pin_mode_in[MODE_LEVEL_BIT])
		else $error("driven select differs from mode level");
	AST_OUT_ON: assert property ($fell(nss_line) && !far_nss_oe_n |-> ##[1:4] !dev_miso_oe_n)
		else $error("slave output not driven after select");
	// Three-wire slave has no select, so its output stays on
	AST_OUT_OFF: assert property (select_pin_mode_in != MODE_THREE_WIRE && $rose(nss_line) &&
		!dev_miso_oe_n |-> ##[1:4] dev_miso_oe_n)
		else $error("slave output not released after deselect");
	AST_OUT_MOVE: assert property (!dev_miso_oe_n && !$past(dev_miso_oe_n) &&
		$changed(dev_miso_out) |-> quiet_cnt_reg <= 4'h4)
		else $error("slave output changed late after an edge");
	AST_SEL_LEAD: assert property ($fell(nss_line) && !far_nss_oe_n |=> $stable(sck_line) [*2])
		else $error("clock edge too soon after select");
	AST_SEL_LAG: assert property ($rose(nss_line) && !far_nss_oe_n |-> quiet_cnt_reg >= 4'h2)
		else $error("select released too soon after last clock edge");
	COV_MASTER: cover property (data_wr && master_en_in && !busy_out);
	COV_COLL: cover property ($rose(write_collision_flag_out));
	COV_SLAVE: cover property ($fell(nss_line) && !far_nss_oe_n);
endmodule
`default_nettype wire

// *** spi_data_port_and_slave_timing_tb.sv ***
// Testbench: port and far end on one link, master and slave transfers.
// Assumes package, interface, FIFO, both ends and checker compile first.
`timescale 1ns/1ps
`default_nettype none
module spi_data_port_and_slave_timing_tb
	import spd_pkg::*;
;
	logic clk_in = 1'b0;
	logic arst_n_in = 1'b0;
	logic [7:0] addr, wdata, rdata, div, half, rx_far, far_tx, got;
	logic wr, rd, m_en, idle, phase, act_m, start, clr_d, clr_c, clr_o;
	logic [1:0] mode;
	logic dev_busy, done, coll_f, ovr_f, tx_e, rx_e, irq, far_busy, rx_v;
	int error_cnt = 0;
	int n_compared = 0;
	int cycles = 0;
	int n_rxv = 0;
	logic [7:0] exp_q[$];
	logic [7:0] corner[4] = '{8'h00, 8'hff, 8'h80, 8'h01};
	always #2.5 clk_in = ~clk_in;
	spd_link_if spd_link_if_inst ();
	spd_device spd_device_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
		.sfr_addr_in(addr), .sfr_wr_in(wr), .sfr_rd_in(rd), .sfr_wdata_in(wdata),
		.sfr_rdata_out(rdata), .port_enable_in(1'b1), .master_en_in(m_en),
		.clock_idle_level_in(idle), .clock_sample_phase_in(phase),
		.clock_rate_divider_in(div), .select_pin_mode_in(mode), .clr_done_in(clr_d),
		.clr_collision_in(clr_c), .clr_overrun_in(clr_o), .busy_out(dev_busy),
		.done_flag_out(done), .write_collision_flag_out(coll_f), .overrun_flag_out(ovr_f),
		.tx_empty_out(tx_e), .rx_empty_out(rx_e), .irq_out(irq), .link(spd_link_if_inst.dev));
	spd_far_end spd_far_end_inst (.clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(1'b1),
		.act_master_in(act_m), .clock_idle_level_in(idle), .clock_sample_phase_in(phase),
		.half_period_in(half), .start_in(start), .tx_byte_in(far_tx), .rx_byte_out(rx_far),
		.rx_valid_out(rx_v), .busy_out(far_busy), .link(spd_link_if_inst.far));
	spd_link_checker spd_link_checker_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
		.sck_line(spd_link_if_inst.sck_line), .nss_line(spd_link_if_inst.nss_line),
		.dev_sck_oe_n(spd_link_if_inst.dev_sck_oe_n),
		.dev_miso_out(spd_link_if_inst.dev_miso_out),
		.dev_miso_oe_n(spd_link_if_inst.dev_miso_oe_n),
		.far_nss_oe_n(spd_link_if_inst.far_nss_oe_n), .master_en_in(m_en),
		.clock_idle_level_in(idle), .clock_rate_divider_in(div), .select_pin_mode_in(mode),
		.sfr_addr_in(addr), .sfr_wr_in(wr), .clr_collision_in(clr_c), .busy_out(dev_busy),
		.write_collision_flag_out(coll_f), .irq_out(irq));
	task automatic summarize();
		$display("compared %0d mismatched %0d", n_compared, error_cnt);
		if (error_cnt == 0 && n_compared > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			error_cnt++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic cyc(input int n);
		repeat (n) @(negedge clk_in);
	endtask
	// Trailing idle cycle keeps back-to-back strobes from sharing a step
	task automatic wr_data(input logic [7:0] b);
		addr = DATA_OFFSET;
		wdata = b;
		wr = 1'b1;
		cyc(1);
		wr = 1'b0;
		cyc(1);
	endtask
	task automatic rd_data(output logic [7:0] b);
		addr = DATA_OFFSET;
		rd = 1'b1;
		cyc(1);
		rd = 1'b0;
		b = rdata;
		cyc(1);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		cyc(4);
		while ((dev_busy !== 1'b0 || far_busy !== 1'b0) && n < 6000)
		begin
			cyc(1);
			n++;
		end
		check("idle", {dev_busy, far_busy}, 8'h00);
		cyc(6);
	endtask
	task automatic xfer(input logic [7:0] db, input logic [7:0] fb, input bit coll, input bit do_rd);
		far_tx = fb;
		if (m_en)
		begin
			mode = 2'b10;
			cyc(8);
			check("nss_low", spd_link_if_inst.nss_line, 8'h00);
			wr_data(db);
		end
		else
		begin
			wr_data(db);
			check("tx_empty", tx_e, 8'h00);
			start = 1'b1;
			cyc(1);
			start = 1'b0;
		end
		if (coll)
		begin
			cyc(10);
			wr_data(8'h5a);
			cyc(3);
			check("coll", {coll_f, irq}, 8'h03);
			clr_c = 1'b1;
			cyc(1);
			clr_c = 1'b0;
			cyc(1);
			check("coll_clr", coll_f, 8'h00);
		end
		wait_idle();
		check("far_rx", rx_far, db);
		if (m_en)
		begin
			check("done", done, 8'h01);
			mode = 2'b11;
		end
		clr_d = 1'b1;
		cyc(2);
		clr_d = 1'b0;
		check("done_clr", done, 8'h00);
		check("nss_high", spd_link_if_inst.nss_line, 8'h01);
		if (do_rd)
		begin
			rd_data(got);
			check("rdata", got, fb);
		end
	endtask
	always @(posedge clk_in)
	begin
		cycles++;
		if (rx_v === 1'b1)
			n_rxv++;
		if (cycles == 60000)
		begin
			error_cnt++;
			summarize();
		end
	end
	initial
	begin
		logic [7:0] b;
		{addr, wdata, far_tx, wr, rd, m_en, idle, phase, act_m, start} = '0;
		{clr_d, clr_c, clr_o} = '0;
		mode = 2'b01;
		div = 8'h06;
		half = 8'h07;
		void'($urandom(32'h9169bc26));
		cyc(2);
		arst_n_in = 1'b1;
		cyc(1);
		check("rdata_rst", rdata, DATA_RESET);
		check("flags_rst", {tx_e, rx_e, irq}, 8'h06);
		// Every idle level and phase, far end as master then as slave
		for (int i = 0; i < 8; i++)
		begin
			idle = i[0];
			phase = i[1];
			div = (i == 7) ? 8'hff : 8'h06 + 8'($urandom_range(3));
			half = 8'h07 + 8'($urandom_range(3));
			m_en = i[2];
			act_m = !i[2];
			mode = i[2] ? 2'b11 : 2'b01;
			cyc(6);
			check("sck_idle", spd_link_if_inst.sck_line, 8'(idle));
			b = (i < 4) ? corner[i] : 8'($urandom);
			xfer(b, ~b ^ 8'($urandom), i == 5, 1'b1);
		end
		// Receive buffer left unread until it overflows
		m_en = 1'b0;
		act_m = 1'b1;
		mode = 2'b01;
		cyc(6);
		for (int k = 0; k < 17; k++)
		begin
			b = 8'($urandom);
			if (k < 16)
				exp_q.push_back(b);
			xfer(~b, b, 1'b0, 1'b0);
			if (k >= 15)
				check("overrun", ovr_f, 8'(k == 16));
		end
		for (int k = 0; k < 16; k++)
		begin
			rd_data(got);
			check("fifo", got, exp_q[k]);
		end
		check("rx_empty", rx_e, 8'h01);
		rd_data(got);
		check("rd_empty", got, exp_q[15]);
		clr_o = 1'b1;
		cyc(1);
		clr_o = 1'b0;
		cyc(2);
		check("ovr_clr", ovr_f, 8'h00);
		// Three-wire slave loads on entry; new byte keeps the bit on the line
		b = {~b[0], 7'($urandom)};
		wr_data(b);
		mode = MODE_THREE_WIRE;
		far_tx = ~b;
		start = 1'b1;
		cyc(1);
		start = 1'b0;
		cyc(200);
		check("three_far", rx_far, b);
		rd_data(got);
		check("three_rx", got, ~b);
		check("rx_valid", 8'(n_rxv), 8'h1a);
		summarize();
	end
endmodule
`default_nettype wire
